// [dv/ibe_peer.sv]
`timescale 1ns/100ps
// bus neighbour: a slave that answers the engine, and a master that drives it
module ibe_peer
(
	// system clock, only used to count stretch time
	input wire logic mclk,
	// resolved bus levels
	input wire logic scl,
	input wire logic sda,
	// pull-low enables
	output logic scl_oe,
	output logic sda_oe
);
	logic s_scl = 1'b0;
	logic s_sda = 1'b0;
	logic m_scl = 1'b0;
	logic m_sda = 1'b0;
	logic serve_en = 1'b1;
	logic ack_en = 1'b1;
	logic rs = 1'b0;
	int stretch = 0;
	logic [7:0] tx_q[$];
	logic [7:0] got_q[$];

	// a released line is not pulled, so the pull-ups make it read high
	assign scl_oe = s_scl | m_scl;
	assign sda_oe = s_sda | m_sda;

	// slave byte loop; data moves at least 4 ns after a fall so it never races the clock edge
	task automatic serve();
		logic [7:0] b;
		logic rd;
		logic first;
		logic ma;
		first = 1'b1;
		rd = 1'b0;
		forever begin
			if (!rd)
			begin
				for (int i = 0; i < 8; i++)
					@(posedge scl) b = {b[6:0], sda};
				@(negedge scl);
				#4;
				s_sda = ack_en;
				s_scl = (stretch > 0);
				repeat (stretch) @(posedge mclk);
				s_scl = 1'b0;
				@(negedge scl);
				#4;
				s_sda = 1'b0;
				got_q.push_back(b);
				if (first)
					rd = b[0];
				first = 1'b0;
			end
			else
			begin
				// the bench queues the byte just before it issues the read, once the last command is done: wait past that
				#40;
				b = (tx_q.size() > 0) ? tx_q.pop_front() : 8'hff;
				for (int i = 7; i >= 0; i--)
				begin
					s_sda = ~b[i];
					@(negedge scl);
					#4;
				end
				s_sda = 1'b0;
				@(posedge scl);
				ma = sda;
				@(negedge scl);
				if (ma)
					wait (1'b0);
			end
		end
	endtask

	// start and repeated start restart the slave, stop parks it
	always
	begin
		if (!rs)
			@(negedge sda iff scl === 1'b1);
		rs = 1'b0;
		fork
			begin
				if (serve_en)
					serve();
				else
					wait (1'b0);
			end
			@(posedge sda iff scl === 1'b1);
			begin
				@(negedge scl);
				@(negedge sda iff scl === 1'b1);
				rs = 1'b1;
			end
		join_any
		disable fork;
		s_scl = 1'b0;
		s_sda = 1'b0;
	end

	// master side: the link clock runs only inside these, 40 ns low and 24 ns high
	task automatic fm_bit(input logic v, output logic r);
		m_sda = ~v;
		#32;
		m_scl = 1'b0;
		wait (scl === 1'b1);
		#24;
		r = sda;
		m_scl = 1'b1;
		#8;
	endtask

	// the gaps give the slave room to turn its data line round between slots
	task automatic fm_byte(input logic [7:0] b, input logic mack, output logic [7:0] r,
		output logic ack);
		#40;
		for (int i = 7; i >= 0; i--)
			fm_bit(b[i], r[i]);
		#40;
		fm_bit(mack, ack);
	endtask

	task automatic fm_start();
		m_sda = 1'b0;
		#32;
		m_scl = 1'b0;
		wait (scl === 1'b1);
		#24;
		m_sda = 1'b1;
		#24;
		m_scl = 1'b1;
		#8;
	endtask

	task automatic fm_stop();
		m_sda = 1'b1;
		#32;
		m_scl = 1'b0;
		wait (scl === 1'b1);
		#24;
		m_sda = 1'b0;
		#24;
	endtask

	// competing master on the engine's clock; it takes over the clock after the byte
	task automatic shadow(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--)
		begin
			m_sda = ~b[i];
			@(posedge scl);
			if (i > 0)
			begin
				@(negedge scl);
				#4;
			end
		end
		#40;
		m_scl = 1'b1;
		#8;
		m_sda = 1'b0;
		#40;
		fm_bit(1'b1, ack);
		fm_stop();
	endtask
endmodule

// [dv/testbench.sv]
`timescale 1ns/100ps
// engine and bus neighbour on a wired-and bus with pull-ups
module testbench;
	import ibe_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic cmd_valid = 1'b0;
	ibe_cmd_t cmd = IBE_CMD_STOP;
	logic [7:0] cmd_data = 8'h00;
	logic cmd_last = 1'b0;
	logic slv_enable = 1'b0;
	logic slv_accept = 1'b1;
	logic slv_tx_valid = 1'b1;
	logic [7:0] slv_tx_data = 8'h3c;
	logic watch_rx = 1'b1;
	logic scl, sda, scl_oe, sda_oe, p_scl_oe, p_sda_oe, cmd_ready, rsp_valid, rsp_nack;
	logic arb_lost, bus_busy, start_seen, stop_seen, slv_tx_load, slv_rx_valid;
	logic slv_is_addr, slv_rw, slv_ten_bit;
	logic [7:0] rsp_data, slv_rx_data;
	int err_count = 0;
	int tests_run = 0;
	int n_start = 0;
	int n_stop = 0;
	int n_arb = 0;
	int cyc = 0;
	logic [8:0] rsp_q[$];
	logic [8:0] rx_q[$];
	logic [7:0] tx_exp[$];

	assign scl = ~(scl_oe | p_scl_oe);
	assign sda = ~(sda_oe | p_sda_oe);

	initial
	forever #4 mclk = ~mclk;

	ibe_engine i_dut (.mclk(mclk), .rst(rst), .scl_in(scl), .scl_o(), .scl_oe(scl_oe),
		.sda_in(sda), .sda_o(), .sda_oe(sda_oe), .low_cnt(16'h000a), .high_cnt(16'h000a),
		.cmd_valid(cmd_valid), .cmd(cmd), .cmd_data(cmd_data), .cmd_last(cmd_last),
		.cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.rsp_nack(rsp_nack), .arb_lost(arb_lost), .bus_busy(bus_busy),
		.start_seen(start_seen), .stop_seen(stop_seen), .slv_enable(slv_enable),
		.slv_accept(slv_accept), .slv_tx_valid(slv_tx_valid), .slv_tx_data(slv_tx_data),
		.slv_tx_load(slv_tx_load), .slv_rx_valid(slv_rx_valid), .slv_rx_data(slv_rx_data),
		.slv_is_addr(slv_is_addr), .slv_rw(slv_rw), .slv_ten_bit(slv_ten_bit));
	ibe_peer i_peer (.mclk(mclk), .scl(scl), .sda(sda), .scl_oe(p_scl_oe),
		.sda_oe(p_sda_oe));

	task automatic check(input logic [8:0] got, input logic [8:0] exp, input string what);
		tests_run++;
		if (got !== exp)
		begin
			err_count++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	function automatic logic [8:0] pop(ref logic [8:0] q[$]);
		return (q.size() > 0) ? q.pop_front() : 9'bx;
	endfunction

	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// outputs are settled at the falling edge; a pulse lasts the whole cycle
	always @(negedge mclk)
	begin
		if (rsp_valid === 1'b1)
			check({rsp_nack, rsp_data}, pop(rsp_q), "master byte");
		if (slv_rx_valid === 1'b1 && slv_enable === 1'b1 && watch_rx)
			check({slv_is_addr, slv_rx_data}, pop(rx_q), "slave byte");
		if (start_seen === 1'b1)
			n_start++;
		if (stop_seen === 1'b1)
			n_stop++;
		if (arb_lost === 1'b1)
			n_arb++;
		if (slv_tx_load === 1'b1)
		begin
			tx_exp.push_back(slv_tx_data);
			slv_tx_data = $urandom;
		end
		cyc++;
		if (cyc == 50000)
		begin
			err_count++;
			$display("CHECK FAILED at %0t: run did not finish", $time);
			results();
		end
	end

	// once ready is seen at a falling edge, hold the request for one cycle, then wait for ready again
	task automatic do_cmd(input ibe_cmd_t c, input logic [7:0] d, input logic last);
		@(negedge mclk);
		while (cmd_ready !== 1'b1)
			@(negedge mclk);
		cmd_valid = 1'b1;
		cmd = c;
		cmd_data = d;
		cmd_last = last;
		@(negedge mclk);
		cmd_valid = 1'b0;
		@(negedge mclk);
		while (cmd_ready !== 1'b1)
			@(negedge mclk);
	endtask

	task automatic wr(input logic [7:0] d, input logic nack);
		rsp_q.push_back({nack, d});
		do_cmd(IBE_CMD_WRITE, d, 1'b0);
	endtask

	task automatic rd(input logic last);
		logic [7:0] t;
		t = $urandom;
		i_peer.tx_q.push_back(t);
		rsp_q.push_back({last, t});
		do_cmd(IBE_CMD_READ, 8'h00, last);
	endtask

	// stop detection lags the pins by a few cycles
	task automatic idle_chk(input string name);
		repeat (4) @(negedge mclk);
		check({4'h0, bus_busy, scl, sda, scl_oe, sda_oe}, 9'h00c, "idle bus");
		$display("test %s done", name);
	endtask

	initial
	begin
		logic [7:0] d, r;
		logic [7:0] w[3];
		logic a;
		void'($urandom(32'h0cb4e0ec));
		repeat (16) @(negedge mclk);
		rst = 1'b0;
		i_peer.stretch = 40;
		d = $urandom;
		w = '{8'ha4, d, 8'ha5};
		do_cmd(IBE_CMD_START, 8'h00, 1'b0);
		wr(8'ha4, 1'b0);
		wr(d, 1'b0);
		do_cmd(IBE_CMD_START, 8'h00, 1'b0);
		wr(8'ha5, 1'b0);
		rd(1'b0);
		rd(1'b1);
		do_cmd(IBE_CMD_STOP, 8'h00, 1'b0);
		foreach (w[i])
			check({1'b0, i_peer.got_q.pop_front()}, {1'b0, w[i]}, "bus byte");
		idle_chk("master");
		i_peer.ack_en = 1'b0;
		do_cmd(IBE_CMD_START, 8'h00, 1'b0);
		wr(8'h90, 1'b1);
		do_cmd(IBE_CMD_STOP, 8'h00, 1'b0);
		idle_chk("nack");
		i_peer.serve_en = 1'b0;
		slv_enable = 1'b1;
		do_cmd(IBE_CMD_START, 8'h00, 1'b0);
		rx_q.push_back({1'b1, 8'he4});
		fork
			do_cmd(IBE_CMD_WRITE, 8'hff, 1'b0);
			i_peer.shadow(8'he4, a);
		join
		check({8'h00, a}, 9'h000, "ack after loss");
		check(9'(n_arb), 9'h001, "loss count");
		idle_chk("arbitration");
		d = $urandom;
		rx_q.push_back({1'b1, 8'ha4});
		rx_q.push_back({1'b0, d});
		rx_q.push_back({1'b0, 8'h5a});
		i_peer.fm_start();
		i_peer.fm_byte(8'ha4, 1'b1, r, a);
		check({8'h00, a}, 9'h000, "address ack");
		i_peer.fm_byte(d, 1'b1, r, a);
		check({8'h00, a}, 9'h000, "data ack");
		@(negedge mclk);
		slv_accept = 1'b0;
		i_peer.fm_byte(8'h5a, 1'b1, r, a);
		check({8'h00, a}, 9'h001, "refused byte");
		i_peer.fm_stop();
		idle_chk("slave write");
		@(negedge mclk);
		slv_accept = 1'b1;
		rx_q.push_back({1'b1, 8'hf2});
		i_peer.fm_start();
		i_peer.fm_byte(8'hf2, 1'b1, r, a);
		check({6'h00, slv_ten_bit, slv_rw, a}, 9'h004, "long prefix");
		i_peer.fm_stop();
		idle_chk("long address");
		rx_q.push_back({1'b1, 8'ha4});
		rx_q.push_back({1'b1, 8'ha5});
		i_peer.fm_start();
		i_peer.fm_byte(8'ha4, 1'b1, r, a);
		@(negedge mclk);
		slv_tx_valid = 1'b0;
		i_peer.fm_start();
		i_peer.fm_byte(8'ha5, 1'b1, r, a);
		check({7'h00, slv_rw, a}, 9'h002, "read address");
		watch_rx = 1'b0;
		// no send data yet: the slave must hold scl low until it comes
		fork
			i_peer.fm_byte(8'hff, 1'b0, r, a);
			begin
				repeat (30) @(negedge mclk);
				check({8'h00, scl}, 9'h000, "slave stretch");
				slv_tx_valid = 1'b1;
			end
		join
		check({1'b0, r}, {1'b0, tx_exp.pop_front()}, "slave send");
		i_peer.fm_byte(8'hff, 1'b1, r, a);
		check({1'b0, r}, {1'b0, tx_exp.pop_front()}, "last send");
		check({7'h00, sda, sda_oe}, 9'h002, "released after nack");
		i_peer.fm_stop();
		idle_chk("slave read");
		check(9'(n_start), 9'h008, "start count");
		check(9'(n_stop), 9'h006, "stop count");
		results();
	end
endmodule

// [include/ibe_pkg.sv]
package ibe_pkg;
	// two-flop synchroniser depth for the bus lines
	localparam int SYNC_STAGES = 2;
	// default width of the low and high period counts
	localparam int CNT_W = 16;
	// leading five bits that mark a long (10-bit) address byte
	localparam logic [4:0] ADDR10_PREFIX = 5'h1e;
	// bit slot indices inside one byte frame
	localparam logic [3:0] LAST_DATA_BIT = 4'h7;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	// reset level of the line samples: released lines read high
	localparam logic LINE_IDLE = 1'b1;

	// master commands
	typedef enum logic [1:0]
	{
		IBE_CMD_START = 2'b00,
		IBE_CMD_WRITE = 2'b01,
		IBE_CMD_READ = 2'b10,
		IBE_CMD_STOP = 2'b11
	} ibe_cmd_t;

	// master sequencer states
	typedef enum logic [3:0]
	{
		MS_IDLE = 4'b0000,
		MS_HOLD = 4'b0001,
		MS_S_LOW = 4'b0010,
		MS_S_WAITH = 4'b0011,
		MS_S_HIGH = 4'b0100,
		MS_S_FALL = 4'b0101,
		MS_B_LOW = 4'b0110,
		MS_B_WAITH = 4'b0111,
		MS_B_HIGH = 4'b1000,
		MS_P_LOW = 4'b1001,
		MS_P_WAITH = 4'b1010,
		MS_P_HIGH = 4'b1011
	} ibe_mst_t;

	// slave sequencer states
	typedef enum logic [2:0]
	{
		SL_IDLE = 3'b000,
		SL_RX = 3'b001,
		SL_ACK = 3'b010,
		SL_LOAD = 3'b011,
		SL_TX = 3'b100,
		SL_TXACK = 3'b101,
		SL_IGNORE = 3'b110
	} ibe_slv_t;
endpackage

// [verilog/ibe_engine.sv]
`timescale 1ns/100ps
module ibe_engine
#(
	parameter int CNT_W = ibe_pkg::CNT_W
)
(
	// system
	input wire logic mclk,
	input wire logic rst,
	// bus pins, open drain
	input wire logic scl_in,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_o,
	output logic sda_oe,
	// master bit timing, in mclk cycles
	input wire logic [CNT_W-1:0] low_cnt,
	input wire logic [CNT_W-1:0] high_cnt,
	// master command and answer
	input wire logic cmd_valid,
	input wire ibe_pkg::ibe_cmd_t cmd,
	input wire logic [7:0] cmd_data,
	input wire logic cmd_last,
	output logic cmd_ready,
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic rsp_nack,
	output logic arb_lost,
	// bus status
	output logic bus_busy,
	output logic start_seen,
	output logic stop_seen,
	// slave user side
	input wire logic slv_enable,
	input wire logic slv_accept,
	input wire logic slv_tx_valid,
	input wire logic [7:0] slv_tx_data,
	output logic slv_tx_load,
	output logic slv_rx_valid,
	output logic [7:0] slv_rx_data,
	output logic slv_is_addr,
	output logic slv_rw,
	output logic slv_ten_bit
);
	import ibe_pkg::*;

	logic scl_s, sda_s, scl_q_ff, sda_q_ff, nxt_scl_q, nxt_sda_q;
	logic start_det, stop_det, scl_rise, scl_fall;
	logic busy_ff, nxt_busy, start_seen_ff, stop_seen_ff;

	// bus lines cross into mclk before anything looks at them
	ibe_sync #(.W(2), .STAGES(SYNC_STAGES)) u_sync
	(
		.mclk(mclk),
		.rst(rst),
		.din({scl_in, sda_in}),
		.dout({scl_s, sda_s})
	);

	assign start_det = scl_q_ff & scl_s & sda_q_ff & ~sda_s;
	assign stop_det = scl_q_ff & scl_s & ~sda_q_ff & sda_s;
	assign scl_rise = ~scl_q_ff & scl_s;
	assign scl_fall = scl_q_ff & ~scl_s;

	// line history and busy tracking
	always_comb
	begin
		nxt_scl_q = scl_s;
		nxt_sda_q = sda_s;
		nxt_busy = busy_ff;
		if (start_det)
			nxt_busy = 1'b1;
		else if (stop_det)
			nxt_busy = 1'b0;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			scl_q_ff <= LINE_IDLE;
			sda_q_ff <= LINE_IDLE;
			busy_ff <= 1'b0;
			start_seen_ff <= 1'b0;
			stop_seen_ff <= 1'b0;
		end
		else
		begin
			scl_q_ff <= nxt_scl_q;
			sda_q_ff <= nxt_sda_q;
			busy_ff <= nxt_busy;
			start_seen_ff <= start_det;
			stop_seen_ff <= stop_det;
		end
	end

	// ---------------- master sequencer ----------------
	ibe_mst_t m_st_ff, nxt_m_st;
	logic [CNT_W-1:0] m_cnt_ff, nxt_m_cnt, cnt_inc;
	logic [3:0] m_bit_ff, nxt_m_bit;
	logic [7:0] m_sh_ff, nxt_m_sh, rsp_data_ff, nxt_rsp_data;
	logic m_rd_ff, nxt_m_rd, m_last_ff, nxt_m_last, m_lost_ff, nxt_m_lost;
	logic m_nak_ff, nxt_m_nak, m_sda_ff, nxt_m_sda, m_scl_ff, nxt_m_scl;
	logic rsp_valid_ff, nxt_rsp_valid, rsp_nack_ff, nxt_rsp_nack, arb_ff, nxt_arb;
	logic cmd_ready_ff, nxt_cmd_ready, take, lo_done, hi_done, m_drv, arb_hit;

	assign take = cmd_valid & cmd_ready_ff;
	assign cnt_inc = m_cnt_ff + 1'b1;
	assign lo_done = m_cnt_ff >= low_cnt;
	assign hi_done = m_cnt_ff >= high_cnt;
	// data bits come from the shifter; the ack slot is ours only when reading
	assign m_drv = (m_bit_ff == BYTE_BITS) ? (m_rd_ff & ~m_last_ff) :
		(~m_rd_ff & ~m_sh_ff[7] & ~m_lost_ff);
	// every written bit is checked, address and data alike
	assign arb_hit = ~m_rd_ff & (m_bit_ff != BYTE_BITS) & ~m_sda_ff & ~sda_s & ~m_lost_ff;

	// next-state logic; the low and bit-high counters only run while scl really shows the phase
	always_comb
	begin
		nxt_m_st = m_st_ff;
		nxt_m_cnt = m_cnt_ff;
		nxt_m_bit = m_bit_ff;
		nxt_m_sh = m_sh_ff;
		nxt_m_rd = m_rd_ff;
		nxt_m_last = m_last_ff;
		nxt_m_lost = m_lost_ff;
		nxt_m_nak = m_nak_ff;
		nxt_m_sda = m_sda_ff;
		nxt_m_scl = m_scl_ff;
		nxt_rsp_valid = 1'b0;
		nxt_rsp_data = rsp_data_ff;
		nxt_rsp_nack = rsp_nack_ff;
		nxt_arb = 1'b0;
		case (m_st_ff)
			MS_IDLE:
			begin
				nxt_m_scl = 1'b0;
				nxt_m_sda = 1'b0;
				if (take && cmd == IBE_CMD_START)
				begin
					nxt_m_st = MS_S_HIGH;
					nxt_m_cnt = '0;
					nxt_m_lost = 1'b0;
				end
			end
			MS_HOLD:
				if (take) // no byte limit: hold loops until a stop
				begin
					nxt_m_cnt = '0;
					nxt_m_bit = '0;
					nxt_m_sh = cmd_data;
					nxt_m_rd = (cmd == IBE_CMD_READ);
					nxt_m_last = cmd_last;
					case (cmd)
						IBE_CMD_START: nxt_m_st = MS_S_LOW;
						IBE_CMD_STOP: nxt_m_st = MS_P_LOW;
						default: nxt_m_st = MS_B_LOW;
					endcase
				end
			MS_S_LOW, MS_B_LOW, MS_P_LOW:
				if (!scl_s) // sda moves only once scl reads low
				begin
					nxt_m_sda = (m_st_ff == MS_B_LOW) ? m_drv : (m_st_ff == MS_P_LOW);
					nxt_m_cnt = cnt_inc;
					if (lo_done)
					begin
						nxt_m_scl = 1'b0;
						nxt_m_st = (m_st_ff == MS_S_LOW) ? MS_S_WAITH :
							(m_st_ff == MS_P_LOW) ? MS_P_WAITH : MS_B_WAITH;
					end
				end
			MS_S_WAITH, MS_P_WAITH:
				if (scl_s) // stretched or slower clocks hold us here
				begin
					nxt_m_cnt = '0;
					nxt_m_st = (m_st_ff == MS_S_WAITH) ? MS_S_HIGH : MS_P_HIGH;
				end
			MS_B_WAITH:
				if (scl_s)
				begin
					nxt_m_cnt = '0;
					nxt_m_st = MS_B_HIGH;
					if (m_bit_ff == BYTE_BITS)
						nxt_m_nak = sda_s;
					else
						nxt_m_sh = {m_sh_ff[6:0], sda_s};
					if (arb_hit)
					begin
						nxt_m_lost = 1'b1;
						nxt_m_sda = 1'b0;
						nxt_arb = 1'b1;
					end
				end
			MS_S_HIGH:
			begin
				nxt_m_cnt = cnt_inc;
				if (hi_done)
				begin
					nxt_m_sda = 1'b1;
					nxt_m_cnt = '0;
					nxt_m_st = MS_S_FALL;
				end
			end
			MS_S_FALL:
			begin
				nxt_m_cnt = cnt_inc;
				if (hi_done)
				begin
					nxt_m_scl = 1'b1;
					nxt_m_st = MS_HOLD;
				end
			end
			MS_B_HIGH:
			begin
				nxt_m_cnt = cnt_inc;
				// first master to finish its high period, or a foreign fall, ends it
				if (hi_done || !scl_s)
				begin
					nxt_m_cnt = '0;
					nxt_m_scl = 1'b1;
					if (m_lost_ff && m_bit_ff == LAST_DATA_BIT)
					begin
						nxt_m_scl = 1'b0;
						nxt_m_st = MS_IDLE;
					end
					else if (m_bit_ff == BYTE_BITS)
					begin
						nxt_m_st = MS_HOLD;
						nxt_rsp_valid = 1'b1;
						nxt_rsp_data = m_sh_ff;
						nxt_rsp_nack = m_nak_ff;
					end
					else
					begin
						nxt_m_bit = m_bit_ff + 4'h1;
						nxt_m_st = MS_B_LOW;
					end
				end
			end
			MS_P_HIGH:
			begin
				nxt_m_cnt = cnt_inc;
				if (hi_done)
				begin
					nxt_m_sda = 1'b0;
					nxt_m_st = MS_IDLE;
				end
			end
			default: nxt_m_st = MS_IDLE;
		endcase
		// someone else closed the bus under us: give it up
		if (stop_det && m_st_ff != MS_IDLE)
		begin
			nxt_m_st = MS_IDLE;
			nxt_m_scl = 1'b0;
			nxt_m_sda = 1'b0;
			nxt_arb = 1'b1;
		end
		nxt_cmd_ready = (nxt_m_st == MS_HOLD) || (nxt_m_st == MS_IDLE && !nxt_busy);
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			m_st_ff <= MS_IDLE;
			m_cnt_ff <= '0;
			m_bit_ff <= '0;
			m_sh_ff <= 8'h00;
			m_rd_ff <= 1'b0;
			m_last_ff <= 1'b0;
			m_lost_ff <= 1'b0;
			m_nak_ff <= 1'b0;
			m_sda_ff <= 1'b0;
			m_scl_ff <= 1'b0;
			rsp_valid_ff <= 1'b0;
			rsp_data_ff <= 8'h00;
			rsp_nack_ff <= 1'b0;
			arb_ff <= 1'b0;
			cmd_ready_ff <= 1'b0;
		end
		else
		begin
			m_st_ff <= nxt_m_st;
			m_cnt_ff <= nxt_m_cnt;
			m_bit_ff <= nxt_m_bit;
			m_sh_ff <= nxt_m_sh;
			m_rd_ff <= nxt_m_rd;
			m_last_ff <= nxt_m_last;
			m_lost_ff <= nxt_m_lost;
			m_nak_ff <= nxt_m_nak;
			m_sda_ff <= nxt_m_sda;
			m_scl_ff <= nxt_m_scl;
			rsp_valid_ff <= nxt_rsp_valid;
			rsp_data_ff <= nxt_rsp_data;
			rsp_nack_ff <= nxt_rsp_nack;
			arb_ff <= nxt_arb;
			cmd_ready_ff <= nxt_cmd_ready;
		end
	end

	// ---------------- slave sequencer ----------------
	// runs regardless of the master, so a lost master is already a receiver
	ibe_slv_t s_st_ff, nxt_s_st;
	logic [3:0] s_bit_ff, nxt_s_bit;
	logic [7:0] s_sh_ff, nxt_s_sh, rx_data_ff, nxt_rx_data;
	logic s_sda_ff, nxt_s_sda, s_scl_ff, nxt_s_scl, s_first_ff, nxt_s_first;
	logic s_addr_ff, nxt_s_addr, s_totx_ff, nxt_s_totx, s_nak_ff, nxt_s_nak;
	logic s_rw_ff, nxt_s_rw, s_ten_ff, nxt_s_ten, is_addr_ff, nxt_is_addr;
	logic rx_valid_ff, nxt_rx_valid, tx_load_ff, nxt_tx_load;

	always_comb
	begin
		nxt_s_st = s_st_ff;
		nxt_s_bit = s_bit_ff;
		nxt_s_sh = s_sh_ff;
		nxt_s_sda = s_sda_ff;
		nxt_s_scl = s_scl_ff;
		nxt_s_first = s_first_ff;
		nxt_s_addr = s_addr_ff;
		nxt_s_totx = s_totx_ff;
		nxt_s_nak = s_nak_ff;
		nxt_s_rw = s_rw_ff;
		nxt_s_ten = s_ten_ff;
		nxt_is_addr = is_addr_ff;
		nxt_rx_data = rx_data_ff;
		nxt_rx_valid = 1'b0;
		nxt_tx_load = 1'b0;
		if (!slv_enable || stop_det)
		begin
			nxt_s_st = SL_IDLE;
			nxt_s_sda = 1'b0;
			nxt_s_scl = 1'b0;
		end
		else if (start_det) // also a repeated start in the middle of anything
		begin
			nxt_s_st = SL_RX;
			nxt_s_bit = '0;
			nxt_s_first = 1'b1;
			nxt_s_addr = 1'b1;
			nxt_s_sda = 1'b0;
			nxt_s_scl = 1'b0;
		end
		else
			case (s_st_ff)
				SL_RX:
				begin
					if (scl_rise)
					begin
						nxt_s_sh = {s_sh_ff[6:0], sda_s};
						nxt_s_bit = s_bit_ff + 4'h1;
					end
					if (scl_fall && s_bit_ff == BYTE_BITS)
					begin
						nxt_rx_valid = 1'b1;
						nxt_rx_data = s_sh_ff;
						nxt_is_addr = s_addr_ff;
						nxt_s_bit = '0;
						nxt_s_first = 1'b0;
						nxt_s_addr = 1'b0;
						nxt_s_totx = 1'b0;
						if (s_first_ff)
						begin
							nxt_s_rw = s_sh_ff[0];
							nxt_s_ten = (s_sh_ff[7:3] == ADDR10_PREFIX);
							nxt_s_addr = (s_sh_ff[7:3] == ADDR10_PREFIX) & ~s_sh_ff[0];
							nxt_s_totx = s_sh_ff[0];
						end
						if (slv_accept)
						begin
							nxt_s_sda = 1'b1;
							nxt_s_st = SL_ACK;
						end
						else
							nxt_s_st = SL_IGNORE;
					end
				end
				SL_ACK:
					if (scl_fall)
					begin
						nxt_s_sda = 1'b0;
						nxt_s_st = s_totx_ff ? SL_LOAD : SL_RX;
					end
				SL_LOAD:
					// no data yet: stretch scl rather than send garbage
					if (slv_tx_valid)
					begin
						nxt_s_sh = slv_tx_data;
						nxt_s_sda = ~slv_tx_data[7];
						nxt_s_scl = 1'b0;
						nxt_s_bit = '0;
						nxt_tx_load = 1'b1;
						nxt_s_st = SL_TX;
					end
					else
						nxt_s_scl = 1'b1;
				SL_TX:
				begin
					if (scl_rise)
						nxt_s_bit = s_bit_ff + 4'h1;
					if (scl_fall)
					begin
						if (s_bit_ff == BYTE_BITS)
						begin
							nxt_s_sda = 1'b0;
							nxt_s_st = SL_TXACK;
						end
						else
						begin
							nxt_s_sh = {s_sh_ff[6:0], 1'b0};
							nxt_s_sda = ~s_sh_ff[6];
						end
					end
				end
				SL_TXACK:
				begin
					if (scl_rise)
						nxt_s_nak = sda_s;
					if (scl_fall)
						nxt_s_st = s_nak_ff ? SL_IGNORE : SL_LOAD;
				end
				SL_IDLE, SL_IGNORE:
				begin
					nxt_s_sda = 1'b0;
					nxt_s_scl = 1'b0;
				end
				default: nxt_s_st = SL_IDLE;
			endcase
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			s_st_ff <= SL_IDLE;
			s_bit_ff <= '0;
			s_sh_ff <= 8'h00;
			s_sda_ff <= 1'b0;
			s_scl_ff <= 1'b0;
			s_first_ff <= 1'b0;
			s_addr_ff <= 1'b0;
			s_totx_ff <= 1'b0;
			s_nak_ff <= 1'b0;
			s_rw_ff <= 1'b0;
			s_ten_ff <= 1'b0;
			is_addr_ff <= 1'b0;
			rx_data_ff <= 8'h00;
			rx_valid_ff <= 1'b0;
			tx_load_ff <= 1'b0;
		end
		else
		begin
			s_st_ff <= nxt_s_st;
			s_bit_ff <= nxt_s_bit;
			s_sh_ff <= nxt_s_sh;
			s_sda_ff <= nxt_s_sda;
			s_scl_ff <= nxt_s_scl;
			s_first_ff <= nxt_s_first;
			s_addr_ff <= nxt_s_addr;
			s_totx_ff <= nxt_s_totx;
			s_nak_ff <= nxt_s_nak;
			s_rw_ff <= nxt_s_rw;
			s_ten_ff <= nxt_s_ten;
			is_addr_ff <= nxt_is_addr;
			rx_data_ff <= nxt_rx_data;
			rx_valid_ff <= nxt_rx_valid;
			tx_load_ff <= nxt_tx_load;
		end
	end

	// ---------------- pin drivers ----------------
	// enables only ever pull low; an enable of zero is a released line
	logic scl_oe_ff, sda_oe_ff, nxt_scl_oe, nxt_sda_oe;

	always_comb
	begin
		nxt_scl_oe = nxt_m_scl | nxt_s_scl;
		nxt_sda_oe = nxt_m_sda | nxt_s_sda;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			scl_oe_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
		end
		else
		begin
			scl_oe_ff <= nxt_scl_oe;
			sda_oe_ff <= nxt_sda_oe;
		end
	end

	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe = scl_oe_ff;
	assign sda_oe = sda_oe_ff;
	assign cmd_ready = cmd_ready_ff;
	assign rsp_valid = rsp_valid_ff;
	assign rsp_data = rsp_data_ff;
	assign rsp_nack = rsp_nack_ff;
	assign arb_lost = arb_ff;
	assign bus_busy = busy_ff;
	assign start_seen = start_seen_ff;
	assign stop_seen = stop_seen_ff;
	assign slv_tx_load = tx_load_ff;
	assign slv_rx_valid = rx_valid_ff;
	assign slv_rx_data = rx_data_ff;
	assign slv_is_addr = is_addr_ff;
	assign slv_rw = s_rw_ff;
	assign slv_ten_bit = s_ten_ff;

	// ---------------- checks ----------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence s_start_edge;
		scl_q_ff && scl_s && sda_q_ff && !sda_s;
	endsequence
	sequence s_stop_edge;
		scl_q_ff && scl_s && !sda_q_ff && sda_s;
	endsequence
	sequence s_both_idle;
		m_st_ff == MS_IDLE && (s_st_ff == SL_IDLE || s_st_ff == SL_IGNORE);
	endsequence

	idle_release_a: assert property (s_both_idle [*2] |-> !scl_oe_ff && !sda_oe_ff)
		else $error("idle bus still driven");
	start_flag_a: assert property (s_start_edge |=> start_seen_ff && busy_ff)
		else $error("start not reported");
	stop_flag_a: assert property (s_stop_edge |=> stop_seen_ff && !busy_ff)
		else $error("stop not reported");
	tx_stable_a: assert property ((s_st_ff == SL_TX && scl_q_ff && scl_s) |-> $stable(s_sda_ff))
		else $error("slave data moved while scl high");
	slave_ack_a: assert property ((s_st_ff == SL_RX && scl_fall && s_bit_ff == BYTE_BITS
		&& slv_accept && slv_enable && !stop_det && !start_det) |=> s_st_ff == SL_ACK && s_sda_ff)
		else $error("accepted byte not acknowledged");
	nack_release_a: assert property (s_st_ff == SL_IGNORE |-> !s_sda_ff && !s_scl_ff)
		else $error("slave drives after nack");
	read_ack_a: assert property ((m_st_ff == MS_B_LOW && !scl_s && !stop_det && m_rd_ff
		&& m_bit_ff == BYTE_BITS) |=> m_sda_ff == !m_last_ff)
		else $error("wrong master acknowledge level");
	stretch_wait_a: assert property ((m_st_ff == MS_B_WAITH && !scl_s && !stop_det)
		|=> m_st_ff == MS_B_WAITH && !m_scl_ff)
		else $error("master ran past a held clock");
	arb_loss_a: assert property ((m_st_ff == MS_B_WAITH && scl_s && arb_hit && !stop_det)
		|=> m_lost_ff && arb_ff && !m_sda_ff ##1 !arb_ff)
		else $error("arbitration loss mishandled");
	lost_release_a: assert property (m_lost_ff |-> m_st_ff != MS_HOLD)
		else $error("lost master kept the bus");
	low_hold_a: assert property ((m_st_ff == MS_B_LOW && !scl_s && !lo_done && !stop_det)
		|=> m_st_ff == MS_B_LOW && m_scl_ff)
		else $error("low period cut short");
endmodule

// [verilog/ibe_sync.sv]
`timescale 1ns/100ps
module ibe_sync
#(
	parameter int W = 2,
	parameter int STAGES = 2
)
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// asynchronous levels in, synchronised levels out
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] stg_ff [STAGES];
	logic [W-1:0] nxt_stg [STAGES];

	// shift chain; stage 0 feeds only stage 1
	always_comb
	begin
		nxt_stg[0] = din;
		for (int i = 1; i < STAGES; i++)
			nxt_stg[i] = stg_ff[i-1];
	end

	// released bus lines idle high, so reset to ones
	always_ff @(posedge mclk)
	begin
		for (int i = 0; i < STAGES; i++)
		begin
			if (rst)
				stg_ff[i] <= {W{1'b1}};
			else
				stg_ff[i] <= nxt_stg[i];
		end
	end

	assign dout = stg_ff[STAGES-1];
endmodule
